// *** include/usf_pkg.sv ***
// usf_pkg: register map, field positions and timing constants of the status flag block
package usf_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_DATA     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    // flag positions in the status byte; irq status and mask use bits 7..4 alike
    localparam int TX_EMPTY_POS = 7;
    localparam int TX_DONE_POS  = 6;
    localparam int RX_FULL_POS  = 5;
    localparam int IDLE_POS     = 4;
    localparam int FLAG_LSB     = 4;
    // control register fields
    localparam int CTRL_BRK_POS     = 0;
    localparam int CTRL_RE_POS      = 2;
    localparam int CTRL_TXE_POS     = 3;
    localparam int CTRL_IDLESEL_POS = 4;
    localparam int CTRL_NINE_POS    = 5;
    // reset values
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic       TX_FLAG_RESET  = 1'b1;
    localparam logic       RX_FLAG_RESET  = 1'b0;
    // timing: oversampling, default divider, character lengths in bit times
    localparam int OVS_RATE         = 16;
    localparam int BAUD_DIV_DEFAULT = 8;
    localparam int CHAR_BITS_8      = 10;
    localparam int CHAR_BITS_9      = 11;
    // bus response
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** rtl/usf_flag.sv ***
// usf_flag: one status flag with its read-then-access clearing sequence
`timescale 1ns/10ps
module usf_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // events
    input  wire logic set_evt,
    input  wire logic arm_read,
    input  wire logic clr_access,
    // flag
    output logic      flag
);
    typedef struct packed {
        logic flag;
        logic armed;
    } usf_flag_state_t;

    usf_flag_state_t st;
    usf_flag_state_t next_st;

    // arm on a status read that sees the flag, clear on the next access
    always_comb
    begin
        next_st = st;
        if (arm_read && st.flag)
            next_st.armed = 1'b1;
        if (clr_access && st.armed)
        begin
            next_st.flag  = 1'b0;
            next_st.armed = 1'b0;
        end
        // set wins, so an event in the clearing cycle is kept
        if (set_evt)
            next_st.flag = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '{flag: RESET_VAL, armed: 1'b0};
        else
            st <= next_st;
    end

    assign flag = st.flag;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_flag_clear_cause: assert property ($fell(st.flag) |-> $past(clr_access) && $past(st.armed))
        else $error("flag cleared without armed read and access");
    a_flag_set_wins: assert property (set_evt |=> st.flag && !$past(st.flag) || st.flag)
        else $error("set event lost");
    a_flag_arm_only_set: assert property (arm_read && !st.flag && !st.armed |=> !st.armed)
        else $error("armed by a read that saw the flag clear");
endmodule

// *** rtl/usf_top.sv ***
// usf_top: serial status flags with a small transmitter, receiver and ahb-lite register slave
// Notes on behaviour
// - the status register is four read-only flags in bits 7..4 and writes to it change nothing.
// - the status register is decoded at byte offset 4h.
// - transmit-empty is set by reset and whenever the buffer moves into the shifter.
// - transmit-empty clears on a data write after a status read that saw it set.
// - transmit-complete is set by reset and whenever the transmitter is empty and quiet.
// - transmit-complete clears after an armed read on a data write, enable rise or break.
// - receive-full is set when a finished character moves into the data register.
// - receive-full clears on a data read after a status read that saw it set.
// - idle is set after one character time of high line following activity.
// - with idle-count-select 0 high bits count from just after the start bit.
// - one character time is 10 bit times in 8-bit mode and 11 in 9-bit mode.
// - with idle-count-select 1 counting starts only from the middle of the stop bit.
// - with idle-count-select 1 trailing high data bits and the first half of the stop bit never count.
// - idle clears on a data read after a status read that saw it set.
// - idle sets once per idle stretch and only again after a new received character.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
module usf_top #(
    parameter int BAUD_DIV = usf_pkg::BAUD_DIV_DEFAULT
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    // interrupt
    output logic             irq
);
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} usf_tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } usf_rx_state_t;

    typedef struct packed {
        logic [7:0]    ctrl;
        logic [3:0]    irq_stat;
        logic [3:0]    irq_mask;
        logic          dp_write;
        logic [7:0]    dp_addr;
        logic [31:0]   rdata;
        logic          ready;
        logic          resp;
        logic [7:0]    div_cnt;
        usf_tx_state_t tx_state;
        logic [3:0]    tx_os;
        logic [3:0]    tx_bit;
        logic [10:0]   tx_shift;
        logic [8:0]    tx_buf;
        logic          tx_buf_full;
        logic          pre_pend;
        logic          brk_pend;
        logic          txd;
        logic          rx_s1;
        logic          rx_s2;
        usf_rx_state_t rx_state;
        logic [3:0]    rx_os;
        logic [3:0]    rx_bit;
        logic [8:0]    rx_shift;
        logic [8:0]    rx_data;
        logic [7:0]    idle_cnt;
        logic          idle_arm;
        logic          irq;
    } usf_state_t;

    // line idles high, bus always ready
    localparam usf_state_t ST_RESET = '{ready: 1'b1, txd: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1,
        tx_state: TX_IDLE, rx_state: RX_IDLE, ctrl: usf_pkg::CTRL_RESET, default: '0};

    usf_state_t st;
    usf_state_t next_st;

    logic       nine;
    logic       idle_sel;
    logic       os_tick;
    logic       addr_ok;
    logic       rd_status;
    logic       rd_data;
    logic       wr_status;
    logic       wr_data;
    logic       wr_ctrl;
    logic       txen_rise;
    logic       brk_set;
    logic       clr_tx_done;
    logic       ev_tx_empty;
    logic       ev_tx_done;
    logic       ev_rx_full;
    logic       ev_idle;
    logic [3:0] ev_vec;
    logic [7:0] idle_limit;
    logic       tx_empty;
    logic       tx_done;
    logic       rx_full;
    logic       idle_flag;
    logic [3:0] flags4;

    assign flags4 = {tx_empty, tx_done, rx_full, idle_flag};

    // next state of the whole block
    always_comb
    begin
        next_st     = st;
        nine        = st.ctrl[usf_pkg::CTRL_NINE_POS];
        idle_sel    = st.ctrl[usf_pkg::CTRL_IDLESEL_POS];
        os_tick     = st.div_cnt == 8'(BAUD_DIV - 1);
        addr_ok     = hsel && hready && htrans[1];
        rd_status   = addr_ok && !hwrite && haddr[7:0] == usf_pkg::ADDR_STATUS;
        rd_data     = addr_ok && !hwrite && haddr[7:0] == usf_pkg::ADDR_DATA;
        wr_status   = st.dp_write && st.dp_addr == usf_pkg::ADDR_STATUS;
        wr_data     = st.dp_write && st.dp_addr == usf_pkg::ADDR_DATA;
        wr_ctrl     = st.dp_write && st.dp_addr == usf_pkg::ADDR_CTRL;
        txen_rise   = wr_ctrl && hwdata[usf_pkg::CTRL_TXE_POS] && !st.ctrl[usf_pkg::CTRL_TXE_POS];
        brk_set     = wr_ctrl && hwdata[usf_pkg::CTRL_BRK_POS];
        clr_tx_done = wr_data || txen_rise || brk_set;
        ev_tx_empty = 1'b0;
        ev_rx_full  = 1'b0;
        ev_idle     = 1'b0;
        idle_limit  = nine ? 8'(usf_pkg::CHAR_BITS_9 * usf_pkg::OVS_RATE)
                           : 8'(usf_pkg::CHAR_BITS_8 * usf_pkg::OVS_RATE);

        // address phase: capture write target, prepare read data for the data phase
        next_st.dp_write = addr_ok && hwrite;
        next_st.dp_addr  = haddr[7:0];
        next_st.rdata    = 32'h0000_0000;
        if (addr_ok && !hwrite)
        begin
            case (haddr[7:0])
                usf_pkg::ADDR_CTRL:     next_st.rdata = {24'h00_0000, st.ctrl};
                usf_pkg::ADDR_STATUS:   next_st.rdata = {24'h00_0000, flags4, 4'h0};
                usf_pkg::ADDR_DATA:     next_st.rdata = {23'h00_0000, st.rx_data};
                usf_pkg::ADDR_IRQ_STAT: next_st.rdata = {24'h00_0000, st.irq_stat, 4'h0};
                usf_pkg::ADDR_IRQ_MASK: next_st.rdata = {24'h00_0000, st.irq_mask, 4'h0};
                default:                next_st.rdata = 32'h0000_0000;
            endcase
        end

        // data phase writes; status offset has no write path at all
        if (wr_ctrl)
            next_st.ctrl = hwdata[7:0];
        if (st.dp_write && st.dp_addr == usf_pkg::ADDR_IRQ_MASK)
            next_st.irq_mask = hwdata[7:4];
        if (txen_rise)
            next_st.pre_pend = 1'b1;
        if (brk_set)
            next_st.brk_pend = 1'b1;
        if (wr_data)
        begin
            next_st.tx_buf      = hwdata[8:0];
            next_st.tx_buf_full = 1'b1;
        end

        // one enable pulse per oversample period
        next_st.div_cnt = os_tick ? 8'h00 : st.div_cnt + 8'h01;

        // transmitter: preamble first, then break, then data
        if (os_tick)
        begin
            case (st.tx_state)
                TX_IDLE:
                begin
                    next_st.tx_os  = 4'h0;
                    next_st.tx_bit = nine ? 4'(usf_pkg::CHAR_BITS_9) : 4'(usf_pkg::CHAR_BITS_8);
                    if (st.ctrl[usf_pkg::CTRL_TXE_POS])
                    begin
                        if (st.pre_pend)
                        begin
                            next_st.tx_shift = 11'h7ff;
                            next_st.pre_pend = 1'b0;
                            next_st.tx_state = TX_SHIFT;
                        end
                        else if (st.brk_pend)
                        begin
                            next_st.tx_shift = 11'h000;
                            // another break follows while the control stays set
                            next_st.brk_pend = st.ctrl[usf_pkg::CTRL_BRK_POS];
                            next_st.tx_state = TX_SHIFT;
                        end
                        else if (st.tx_buf_full && !wr_data)
                        begin
                            // a write in this cycle defers the load so no data is lost
                            next_st.tx_shift    = nine ? {1'b1, st.tx_buf, 1'b0}
                                                       : {2'b11, st.tx_buf[7:0], 1'b0};
                            next_st.tx_buf_full = 1'b0;
                            next_st.tx_state    = TX_SHIFT;
                            ev_tx_empty         = 1'b1;
                        end
                    end
                end
                TX_SHIFT:
                begin
                    next_st.tx_os = st.tx_os + 4'h1;
                    if (st.tx_os == 4'h0)
                    begin
                        if (st.tx_bit == 4'h0)
                        begin
                            next_st.tx_state = TX_IDLE;
                            next_st.txd      = 1'b1;
                        end
                        else
                        begin
                            next_st.txd      = st.tx_shift[0];
                            next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
                            next_st.tx_bit   = st.tx_bit - 4'h1;
                        end
                    end
                end
                default: next_st.tx_state = TX_IDLE;
            endcase
        end

        // complete: empty buffer, nothing queued or shifting, no clearing access now
        ev_tx_done = tx_empty && !tx_done && st.tx_state == TX_IDLE && !st.tx_buf_full
                     && !st.pre_pend && !st.brk_pend && !clr_tx_done;

        // receive line synchroniser
        next_st.rx_s1 = rxd;
        next_st.rx_s2 = st.rx_s1;

        if (os_tick)
        begin
            // idle counter: whole frame after start bit, or only between frames
            if (st.rx_s2 && (!idle_sel || st.rx_state == RX_IDLE))
            begin
                if (st.idle_cnt < idle_limit)
                    next_st.idle_cnt = st.idle_cnt + 8'h01;
                if (st.idle_cnt == idle_limit - 8'h01 && st.idle_arm)
                begin
                    ev_idle          = 1'b1;
                    next_st.idle_arm = 1'b0;
                end
            end
            else
                next_st.idle_cnt = 8'h00;

            // receiver, sampling each bit in its middle
            case (st.rx_state)
                RX_IDLE:
                begin
                    next_st.rx_os = 4'h0;
                    if (!st.rx_s2 && st.ctrl[usf_pkg::CTRL_RE_POS])
                        next_st.rx_state = RX_START;
                end
                RX_START:
                begin
                    next_st.rx_os = st.rx_os + 4'h1;
                    if (st.rx_os == 4'(usf_pkg::OVS_RATE / 2 - 1))
                    begin
                        next_st.rx_os    = 4'h0;
                        next_st.rx_bit   = 4'h0;
                        // a short glitch is not a start bit
                        next_st.rx_state = st.rx_s2 ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    next_st.rx_os = st.rx_os + 4'h1;
                    if (st.rx_os == 4'(usf_pkg::OVS_RATE - 1))
                    begin
                        next_st.rx_shift = {st.rx_s2, st.rx_shift[8:1]};
                        next_st.rx_bit   = st.rx_bit + 4'h1;
                        if (st.rx_bit == (nine ? 4'(usf_pkg::CHAR_BITS_9 - 3)
                                               : 4'(usf_pkg::CHAR_BITS_8 - 3)))
                            next_st.rx_state = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    next_st.rx_os = st.rx_os + 4'h1;
                    if (st.rx_os == 4'(usf_pkg::OVS_RATE - 1))
                    begin
                        // framing is not checked; overrun simply overwrites
                        next_st.rx_data  = nine ? st.rx_shift : {1'b0, st.rx_shift[8:1]};
                        next_st.idle_arm = 1'b1;
                        next_st.rx_state = RX_IDLE;
                        ev_rx_full       = 1'b1;
                    end
                end
                default: next_st.rx_state = RX_IDLE;
            endcase
        end

        // sticky interrupt status, write one to clear, new events win
        ev_vec           = {ev_tx_empty, ev_tx_done, ev_rx_full, ev_idle};
        next_st.irq_stat = ev_vec | (st.irq_stat & ~((st.dp_write
                           && st.dp_addr == usf_pkg::ADDR_IRQ_STAT) ? hwdata[7:4] : 4'h0));
        next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
        next_st.ready    = 1'b1;
        next_st.resp     = usf_pkg::HRESP_OKAY;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // outputs straight from the state register
    assign hreadyout = st.ready;
    assign hresp     = st.resp;
    assign hrdata    = st.rdata;
    assign txd       = st.txd;
    assign irq       = st.irq;

    // the four flags; resets of the transmit pair come from the package
    usf_flag #(.RESET_VAL(usf_pkg::TX_FLAG_RESET)) u_tx_empty (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .set_evt    (ev_tx_empty),
        .arm_read   (rd_status),
        .clr_access (wr_data),
        .flag       (tx_empty)
    );
    usf_flag #(.RESET_VAL(usf_pkg::TX_FLAG_RESET)) u_tx_done (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .set_evt    (ev_tx_done),
        .arm_read   (rd_status),
        .clr_access (clr_tx_done),
        .flag       (tx_done)
    );
    usf_flag #(.RESET_VAL(usf_pkg::RX_FLAG_RESET)) u_rx_full (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .set_evt    (ev_rx_full),
        .arm_read   (rd_status),
        .clr_access (rd_data),
        .flag       (rx_full)
    );
    usf_flag #(.RESET_VAL(usf_pkg::RX_FLAG_RESET)) u_idle (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .set_evt    (ev_idle),
        .arm_read   (rd_status),
        .clr_access (rd_data),
        .flag       (idle_flag)
    );

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_status_write_ro: assert property (wr_status && !rd_data && ev_vec == 4'h0 |=> flags4 == $past(flags4))
        else $error("status write changed a flag");
    a_status_read_map: assert property (rd_status |=> hrdata == {24'h00_0000, $past(flags4), 4'h0})
        else $error("status read data wrong");
    a_tx_empty_load: assert property (ev_tx_empty |=> tx_empty && !st.tx_buf_full && st.tx_state == TX_SHIFT)
        else $error("buffer load did not set transmit empty");
    a_tx_done_idle: assert property (ev_tx_done |=> tx_done && st.tx_state == TX_IDLE)
        else $error("idle transmitter did not set complete");
    a_rx_full_move: assert property (ev_rx_full |=> rx_full && st.idle_arm && st.rx_state == RX_IDLE)
        else $error("received character did not set receive full");
    a_idle_limit: assert property (ev_idle |-> st.rx_s2 && st.idle_cnt + 8'h01 == idle_limit)
        else $error("idle set at wrong count");
    a_idle_once: assert property (ev_idle |=> idle_flag && !st.idle_arm)
        else $error("idle not set once");
    a_idle_after_stop: assert property (idle_sel && st.rx_state == RX_DATA |-> st.idle_cnt == 8'h00)
        else $error("idle counted inside a frame");
    a_idle_from_start: assert property (!idle_sel && st.rx_state == RX_DATA && st.rx_s2 && os_tick
        && st.idle_cnt < 8'h20 |=> st.idle_cnt == $past(st.idle_cnt) + 8'h01)
        else $error("high data bit not counted");

    c_tx_empty_clear: cover property (tx_empty ##1 !tx_empty);
    c_tx_done_clear: cover property (tx_done ##1 !tx_done);
    c_rx_full_set: cover property (ev_rx_full);
    c_idle_set: cover property (ev_idle);
endmodule

// *** testbench/usf_remote.sv ***
// usf_remote: far serial station that sends frames on rxd and decodes txd
`timescale 1ns/10ps
module usf_remote #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input  wire logic hclk,
    // serial lines
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] last_rx;

    // line idles high between frames
    initial rxd = 1'b1;

    // start, 8 data lsb first, one stop; gap idles first to act slow
    task send_char(input logic [7:0] d, input int gap);
        logic [9:0] frm;
        frm = {1'b1, d, 1'b0};
        repeat (gap * BIT_CLKS) @(posedge hclk);
        for (int i = 0; i < 10; i++)
        begin
            rxd <= frm[i];
            repeat (BIT_CLKS) @(posedge hclk);
        end
    endtask

    // mid-bit sampling of txd; a break simply decodes as zero
    initial
    begin
        last_rx = 8'h00;
        forever
        begin
            @(negedge txd);
            repeat (BIT_CLKS / 2) @(posedge hclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge hclk);
                last_rx[i] = txd;
            end
            repeat (BIT_CLKS) @(posedge hclk);
        end
    end
endmodule

// *** testbench/uart_status_flags_tx_rx_idle_tb.sv ***
// uart_status_flags_tx_rx_idle_tb: register-level test of the serial status flags
`timescale 1ns/10ps
module uart_status_flags_tx_rx_idle_tb;
    localparam int BC = 16; // clocks per bit with BAUD_DIV 1
    localparam logic [7:0] S = usf_pkg::ADDR_STATUS;
    localparam logic [7:0] C = usf_pkg::ADDR_CTRL;
    localparam logic [7:0] D = usf_pkg::ADDR_DATA;
    localparam logic [7:0] IS = usf_pkg::ADDR_IRQ_STAT;
    localparam logic [7:0] IM = usf_pkg::ADDR_IRQ_MASK;
    localparam logic [31:0] TXEN = 32'h1 << usf_pkg::CTRL_TXE_POS;
    localparam logic [31:0] RE = 32'h1 << usf_pkg::CTRL_RE_POS;
    localparam logic [31:0] IDLESEL = 32'h1 << usf_pkg::CTRL_IDLESEL_POS;
    localparam logic [31:0] BRK = 32'h1 << usf_pkg::CTRL_BRK_POS;
    localparam logic [31:0] NINE = 32'h1 << usf_pkg::CTRL_NINE_POS;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rxd;
    logic        txd;
    logic        irq;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // 20 MHz
    always #25 hclk = ~hclk;

    usf_top #(.BAUD_DIV(1)) u_usf_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .irq(irq)
    );

    usf_remote #(.BIT_CLKS(BC)) u_usf_remote (
        .hclk(hclk),
        .txd(txd),
        .rxd(rxd)
    );

    task end_sim;
        $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles needed
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_sim;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one single transfer: address phase held until hready, then data phase
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        check(x, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    task bits(input int n);
        repeat (n * BC) @(posedge hclk);
    endtask

    // main sequence; status reads also arm the clearing sequences
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wr(D, 32'h3c);
        rd(S, 32'hc0);
        wr(S, 32'h0);
        rd(S, 32'hc0);
        rd(8'h14, 32'h0);
        wr(D, 32'h3c);
        rd(S, 32'h0);
        wr(C, TXEN);
        bits(24);
        rd(S, 32'hc0);
        check({24'h0, u_usf_remote.last_rx}, 32'h3c);
        wr(C, 32'h0);
        wr(C, TXEN);
        rd(S, 32'h80);
        bits(12);
        rd(S, 32'hc0);
        wr(C, TXEN | BRK);
        wr(C, TXEN);
        rd(S, 32'h80);
        bits(24);
        rd(S, 32'hc0);
        // receive with interrupt on rx_full only
        wr(IS, 32'hff);
        wr(IM, 32'h20);
        wr(C, TXEN | RE);
        u_usf_remote.send_char(8'h5a, 0);
        bits(1);
        check({31'h0, irq}, 32'h1);
        rd(S, 32'he0);
        // read lands between nine and ten bit times of high line
        bits(7);
        rd(S, 32'he0);
        bits(5);
        rd(S, 32'hf0);
        rd(IS, 32'h30);
        wr(IM, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        rd(D, 32'h5a);
        rd(S, 32'hc0);
        bits(12);
        rd(S, 32'hc0);
        wr(IS, 32'h30);
        rd(IS, 32'h0);
        // all-ones character, idle count from start bit, then from stop
        u_usf_remote.send_char(8'hff, 3);
        bits(3);
        rd(S, 32'hf0);
        rd(D, 32'hff);
        wr(C, TXEN | RE | IDLESEL);
        u_usf_remote.send_char(8'hff, 0);
        bits(3);
        rd(S, 32'he0);
        bits(9);
        rd(S, 32'hf0);
        // nine-bit mode: remote stop lands as data bit 8, idle needs 11 bit times
        rd(D, 32'hff);
        wr(C, TXEN | RE | NINE);
        u_usf_remote.send_char(8'hff, 0);
        bits(1);
        rd(S, 32'he0);
        rd(S, 32'he0);
        bits(1);
        rd(S, 32'hf0);
        rd(D, 32'h1ff);
        end_sim;
    end
endmodule
